// *** verilog/ptnwp_target.sv ***
// Purpose: pci target routing and non-prefetchable single-phase path
// Assumes: target controller decodes bars and drives pci pin timing
// Notes: one request in flight; reads complete as delayed reads
//
// Functional notes
// - accept memory, config and io transactions
// - config cycles handled by core only
// - non-prefetchable bar hits go to np path
// - single-cycle profile sends all memory np
// - np path: single data phase, never bursts
// - reads retried first, completed later
// - np master: single address/data registers
// - prefetchable hits steered to burst path
// - one outstanding np request, one register
// - busy command register: retry new requests
// - memory write and invalidate same as write
// - store first phase, disconnect on it
// - one translated single-cycle master write
// - retried write leaves no stored state
// - burst attempt: keep first phase only
// - no abort for memory; io per decode
// - io writes delayed through np path
// - read data only for exact repeat
// - discard read data after latency timeout
// - during np read, others retried unrecorded
`timescale 1ns/1ps
module ptnwp_target
   import ptnwp_pkg::*;
#(
   parameter bit SINGLE_CYCLE_ONLY = 1'b0,
   parameter int unsigned LAT_LIMIT = LAT_LIMIT_CLK
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // bar decode and translation from the target controller
   input wire logic tgt_hit_np,
   input wire logic tgt_hit_pf,
   input wire logic tgt_hit_io,
   input wire logic tgt_io_abort,
   input wire logic [ADDR_W-1:0] xlate_base,
   // address phase
   input wire logic tgt_start,
   input wire logic [CMD_W-1:0] tgt_cmd,
   input wire logic [ADDR_W-1:0] tgt_addr,
   input wire logic [BE_W-1:0] tgt_be,
   // data phases and end of transaction
   input wire logic tgt_dphase,
   input wire logic [DATA_W-1:0] tgt_wdata,
   input wire logic tgt_end,
   // ordering against the opposite direction
   input wire logic m2p_write_pending,
   // response to the target controller
   output logic tgt_rsp_valid,
   output logic [2:0] tgt_rsp,
   output logic [DATA_W-1:0] tgt_rdata,
   output logic np_busy,
   // non-prefetchable master port
   output logic [ADDR_W-1:0] npm_address,
   output logic npm_write,
   output logic npm_read,
   output logic [DATA_W-1:0] npm_writedata,
   output logic [BE_W-1:0] npm_byteenable,
   input wire logic npm_waitrequest,
   input wire logic [DATA_W-1:0] npm_readdata,
   input wire logic npm_readdatavalid
);
   typedef struct packed {
      ptnwp_state_e st;
      logic [CMD_W-1:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [BE_W-1:0] be;
      logic stale;
      logic rsp_valid;
      ptnwp_rsp_e rsp;
      logic [DATA_W-1:0] rdata;
      logic busy;
      logic [ADDR_W-1:0] m_addr;
      logic m_write;
      logic m_read;
      logic [DATA_W-1:0] m_wdata;
      logic [BE_W-1:0] m_be;
      logic tmr_start;
      logic tmr_stop;
   } ptnwp_top_s;

   ptnwp_top_s r;
   ptnwp_top_s next_r;
   logic tmr_expired;
   logic is_cfg;
   logic is_wr;
   logic is_rd;
   logic is_mem;
   logic pf_route;
   logic np_route;
   logic rd_match;
   logic [ADDR_W-1:0] xlated;

   always_comb begin
      is_cfg = 1'b0;
      is_wr = 1'b0;
      is_rd = 1'b0;
      is_mem = 1'b0;
      case (tgt_cmd)
         CMD_CFG_RD, CMD_CFG_WR: begin
            is_cfg = 1'b1;
         end
         CMD_MEM_WR, CMD_MEM_WRI: begin
            is_wr = 1'b1;
            is_mem = 1'b1;
         end
         // every memory read flavour shares one path
         CMD_MEM_RD, CMD_MEM_RDL, CMD_MEM_RDM: begin
            is_rd = 1'b1;
            is_mem = 1'b1;
         end
         CMD_IO_WR: begin
            is_wr = 1'b1;
         end
         CMD_IO_RD: begin
            is_rd = 1'b1;
         end
         // special cycles, acknowledges and reserved codes ignored
         default: begin
         end
      endcase
   end

   generate
      if (SINGLE_CYCLE_ONLY) begin : g_single
         assign pf_route = 1'b0;
      end else begin : g_burst
         assign pf_route = tgt_hit_pf && is_mem;
      end
   endgenerate

   // np bar, io bar, or pf bar in single-cycle mode
   assign np_route = (tgt_hit_np && is_mem) ||
      (tgt_hit_io && !is_mem) ||
      (SINGLE_CYCLE_ONLY && tgt_hit_pf && is_mem);

   // exact repeat of the held read
   // byte enables count too: a partial repeat stays retried
   assign rd_match = (tgt_cmd == r.cmd) && (tgt_addr == r.addr) &&
      (tgt_be == r.be);

   // keep low bits, replace upper bits with window base
   // one fixed window: cheap, but no per-bar translation table
   assign xlated = {xlate_base[ADDR_W-1:NP_WIN_BITS],
      r.addr[NP_WIN_BITS-1:0]};

   always_comb begin
      next_r = r;
      next_r.rsp_valid = 1'b0;
      next_r.rsp = RSP_NONE;
      next_r.tmr_start = 1'b0;
      next_r.tmr_stop = 1'b0;

      // address phase decisions
      if (tgt_start) begin
         if (is_cfg) begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp = RSP_TO_CFG;
         end else if (pf_route) begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp = RSP_TO_PF;
         end else if (np_route && (is_wr || is_rd)) begin
            next_r.rsp_valid = 1'b1;
            if (tgt_hit_io && !is_mem && tgt_io_abort) begin
               next_r.rsp = RSP_ABORT;
            end else if (r.st == ST_RD_HOLD && is_rd && rd_match &&
               !m2p_write_pending) begin
               next_r.rsp = RSP_RD_DISC;
               next_r.st = ST_IDLE;
               next_r.busy = 1'b0;
               next_r.tmr_stop = 1'b1;
            end else if (r.st != ST_IDLE) begin
               // any read or write in flight retries all others
               next_r.rsp = RSP_RETRY;
            end else if (is_wr) begin
               // capture into the single command register
               // io writes take the same delayed path
               next_r.rsp = RSP_WR_DISC;
               next_r.st = ST_WR_DATA;
               next_r.busy = 1'b1;
               next_r.cmd = tgt_cmd;
               next_r.addr = tgt_addr;
               next_r.be = tgt_be;
            end else begin
               next_r.rsp = RSP_RETRY;
               next_r.st = ST_RD_ISSUE;
               next_r.busy = 1'b1;
               next_r.cmd = tgt_cmd;
               next_r.addr = tgt_addr;
               next_r.be = tgt_be;
               next_r.stale = 1'b0;
               next_r.tmr_start = 1'b1;
            end
         end
      end

      case (r.st)
         ST_IDLE: begin
         end
         ST_WR_DATA: begin
            if (tgt_dphase) begin
               // first phase stored, disconnect already given
               // only this one data phase is used
               next_r.st = ST_WR_ISSUE;
               next_r.m_wdata = tgt_wdata;
               next_r.m_be = tgt_be;
               next_r.m_addr = xlated;
               next_r.m_write = 1'b1;
            end else if (tgt_end) begin
               // initiator gave up without data
               next_r.st = ST_IDLE;
               next_r.busy = 1'b0;
            end
         end
         ST_WR_ISSUE: begin
            // further data phases are ignored here
            // free only once the write is taken
            if (r.m_write && !npm_waitrequest) begin
               next_r.m_write = 1'b0;
               next_r.st = ST_IDLE;
               next_r.busy = 1'b0;
            end
         end
         ST_RD_ISSUE: begin
            // single read from the held address
            if (!r.m_read) begin
               next_r.m_read = 1'b1;
               next_r.m_addr = xlated;
               next_r.m_be = r.be;
            end else if (!npm_waitrequest) begin
               next_r.m_read = 1'b0;
               next_r.st = ST_RD_WAIT;
            end
            if (tmr_expired) begin
               next_r.stale = 1'b1;
            end
         end
         ST_RD_WAIT: begin
            // late data still has to be drained from the port
            if (npm_readdatavalid) begin
               if (r.stale || tmr_expired) begin
                  next_r.st = ST_IDLE;
                  next_r.busy = 1'b0;
               end else begin
                  next_r.rdata = npm_readdata;
                  next_r.st = ST_RD_HOLD;
               end
            end else if (tmr_expired) begin
               next_r.stale = 1'b1;
            end
         end
         ST_RD_HOLD: begin
            if (tmr_expired && !(next_r.st == ST_IDLE)) begin
               next_r.st = ST_IDLE;
               next_r.busy = 1'b0;
            end
         end
         default: begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
         end
      endcase

      // rdata is held through a read completion; tgt_rdata shows r.rdata at all times
      if (next_r.rsp == RSP_RD_DISC) begin
         next_r.rdata = r.rdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   ptnwp_lat_timer #(
      .LIMIT(LAT_LIMIT)
   ) u_lat_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .start(r.tmr_start),
      .stop(r.tmr_stop),
      .expired(tmr_expired)
   );

   // outputs straight from the state register, no glitches
   assign tgt_rsp_valid = r.rsp_valid;
   assign tgt_rsp = r.rsp;
   assign tgt_rdata = r.rdata;
   assign np_busy = r.busy;
   assign npm_address = r.m_addr;
   assign npm_write = r.m_write;
   assign npm_read = r.m_read;
   assign npm_writedata = r.m_wdata;
   assign npm_byteenable = r.m_be;
endmodule // ptnwp_target

// *** pkg/ptnwp_pkg.sv ***
// Purpose: shared constants and types of the pci target write path
// Assumes: 32-bit pci bus, single pci clock
// Notes: command codes follow the pci bus command encoding
package ptnwp_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int CMD_W = 4;
   // low address bits passed through by the translation window
   localparam int NP_WIN_BITS = 20;
   // delayed read latency limit, in pci clocks
   localparam int unsigned LAT_LIMIT_CLK = 32768;
   localparam int LAT_W = 16;

   localparam logic [CMD_W-1:0] CMD_IO_RD = 4'h2;
   localparam logic [CMD_W-1:0] CMD_IO_WR = 4'h3;
   localparam logic [CMD_W-1:0] CMD_MEM_RD = 4'h6;
   localparam logic [CMD_W-1:0] CMD_MEM_WR = 4'h7;
   localparam logic [CMD_W-1:0] CMD_CFG_RD = 4'hA;
   localparam logic [CMD_W-1:0] CMD_CFG_WR = 4'hB;
   localparam logic [CMD_W-1:0] CMD_MEM_RDM = 4'hC;
   localparam logic [CMD_W-1:0] CMD_MEM_RDL = 4'hE;
   localparam logic [CMD_W-1:0] CMD_MEM_WRI = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WR_DATA = 3'b001,
      ST_WR_ISSUE = 3'b010,
      ST_RD_ISSUE = 3'b011,
      ST_RD_WAIT = 3'b100,
      ST_RD_HOLD = 3'b101
   } ptnwp_state_e;

   typedef enum logic [2:0] {
      RSP_NONE = 3'b000,
      RSP_RETRY = 3'b001,
      RSP_WR_DISC = 3'b010,
      RSP_RD_DISC = 3'b011,
      RSP_ABORT = 3'b100,
      RSP_TO_PF = 3'b101,
      RSP_TO_CFG = 3'b110
   } ptnwp_rsp_e;
endpackage

// *** verilog/ptnwp_lat_timer.sv ***
// Purpose: delayed read latency counter
// Assumes: start and stop are one-cycle pulses
// Notes: expired is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module ptnwp_lat_timer
   import ptnwp_pkg::*;
#(
   parameter int unsigned LIMIT = LAT_LIMIT_CLK
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control
   input wire logic start,
   input wire logic stop,
   // status
   output logic expired
);
   typedef struct packed {
      logic running;
      logic [LAT_W-1:0] cnt;
      logic expired;
   } ptnwp_tmr_s;

   localparam logic [LAT_W-1:0] LAST = LAT_W'(LIMIT - 1);

   ptnwp_tmr_s r;
   ptnwp_tmr_s next_r;

   always_comb begin
      next_r = r;
      next_r.expired = 1'b0;
      if (start) begin
         next_r.running = 1'b1;
         next_r.cnt = '0;
      end else if (stop) begin
         next_r.running = 1'b0;
      end else if (r.running) begin
         if (r.cnt == LAST) begin
            next_r.running = 1'b0;
            next_r.expired = 1'b1;
         end else begin
            next_r.cnt = r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired = r.expired;
endmodule // ptnwp_lat_timer

// *** testbench/ptnwp_target_assertions.sv ***
// Purpose: port checks of the np target path
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/1ps
module ptnwp_chk
   import ptnwp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // target side
   input wire logic tgt_start,
   input wire logic [CMD_W-1:0] tgt_cmd,
   input wire logic tgt_hit_np,
   input wire logic tgt_hit_io,
   input wire logic tgt_rsp_valid,
   input wire logic [2:0] tgt_rsp,
   input wire logic np_busy,
   // master port
   input wire logic npm_write,
   input wire logic [ADDR_W-1:0] npm_address,
   input wire logic [DATA_W-1:0] npm_writedata,
   input wire logic npm_waitrequest
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_np_req;
      tgt_start && tgt_hit_np;
   endsequence
   sequence s_wr_cmd;
      tgt_cmd == CMD_MEM_WR || tgt_cmd == CMD_MEM_WRI;
   endsequence
   wr_claim_a:
      assert property (s_np_req ##0 !np_busy ##0 s_wr_cmd |=>
         tgt_rsp_valid && tgt_rsp == RSP_WR_DISC && np_busy)
      else $error("free write not accepted");
   busy_retry_a:
      assert property (s_np_req ##0 np_busy ##0 s_wr_cmd |=>
         tgt_rsp_valid && tgt_rsp == RSP_RETRY)
      else $error("busy write not retried");
   rd_retry_a:
      assert property (s_np_req ##0 !np_busy && tgt_cmd == CMD_MEM_RD
         |=> tgt_rsp == RSP_RETRY && np_busy)
      else $error("new read not retried");
   cfg_core_a:
      assert property (tgt_start && tgt_cmd == CMD_CFG_RD |=>
         tgt_rsp_valid && tgt_rsp == RSP_TO_CFG)
      else $error("config read not sent to core");
   no_abort_a:
      assert property (tgt_start && !tgt_hit_io |=> tgt_rsp != RSP_ABORT)
      else $error("abort without io hit");
   one_beat_a:
      assert property (npm_write && !npm_waitrequest |=> !npm_write)
      else $error("write repeated after accept");
   wr_hold_a:
      assert property (npm_write && npm_waitrequest |=> npm_write &&
         $stable(npm_address) && $stable(npm_writedata))
      else $error("stalled write changed");
   busy_stall_a:
      assert property (npm_write && npm_waitrequest |=> np_busy)
      else $error("register freed before accept");
   busy_wr_a:
      assert property (npm_write |-> np_busy)
      else $error("write without held command");
endmodule // ptnwp_chk
bind ptnwp_target ptnwp_chk u_chk (.sys_clk, .sys_rst, .tgt_start,
   .tgt_cmd, .tgt_hit_np, .tgt_hit_io, .tgt_rsp_valid, .tgt_rsp,
   .np_busy, .npm_write, .npm_address, .npm_writedata, .npm_waitrequest);

// *** testbench/ptnwp_slave_model.sv ***
// Purpose: interconnect slave on the np master port
// Assumes: wait_cyc stall cycles per transfer
// Notes: read data is the address xor a pattern
`timescale 1ns/1ps
module ptnwp_slave_model
   import ptnwp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // control
   input wire logic [3:0] wait_cyc,
   // master port
   input wire logic npm_write,
   input wire logic npm_read,
   input wire logic [ADDR_W-1:0] npm_address,
   input wire logic [DATA_W-1:0] npm_writedata,
   input wire logic [BE_W-1:0] npm_byteenable,
   output logic npm_waitrequest,
   output logic [DATA_W-1:0] npm_readdata,
   output logic npm_readdatavalid
);
   logic [3:0] cnt;
   int wr_cnt;
   logic [ADDR_W-1:0] last_addr;
   logic [DATA_W-1:0] last_data;
   logic [BE_W-1:0] last_be;
   assign npm_waitrequest = cnt < wait_cyc;
   always @(posedge sys_clk) begin
      npm_readdatavalid <= 1'b0;
      // no stale data between beats
      npm_readdata <= ~npm_readdata;
      if (sys_rst) begin
         cnt <= 4'h0;
         wr_cnt <= 0;
         npm_readdata <= 32'h0;
      end else if (npm_write || npm_read) begin
         cnt <= npm_waitrequest ? cnt + 4'h1 : 4'h0;
         if (!npm_waitrequest && npm_write) begin
            wr_cnt <= wr_cnt + 1;
            last_addr <= npm_address;
            last_data <= npm_writedata;
            last_be <= npm_byteenable;
         end
         if (!npm_waitrequest && npm_read) begin
            npm_readdatavalid <= 1'b1;
            npm_readdata <= npm_address ^ 32'h5A5A_5A5A;
         end
      end
   end
endmodule // ptnwp_slave_model

// *** testbench/ptnwp_target_tb_top.sv ***
// Purpose: scenario bench of the np target path
// Assumes: short latency limit of 16
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module ptnwp_target_tb_top
   import ptnwp_pkg::*;
;
   localparam logic [31:0] XB = 32'hABC0_0000;
   logic sys_clk, sys_rst, tgt_start, tgt_dphase, tgt_end;
   logic tgt_hit_np, tgt_hit_pf, tgt_hit_io, tgt_io_abort;
   logic m2p_write_pending, tgt_rsp_valid, np_busy, npm_write, npm_read;
   logic npm_waitrequest, npm_readdatavalid;
   logic [3:0] tgt_cmd, tgt_be, npm_byteenable, wait_cyc;
   logic [2:0] tgt_rsp;
   logic [31:0] xlate_base, tgt_addr, tgt_wdata, tgt_rdata, npm_address;
   logic [31:0] npm_writedata, npm_readdata;
   int err_count, compares;
   ptnwp_target #(.LAT_LIMIT(16)) u_dut (.sys_clk, .sys_rst, .tgt_hit_np,
      .tgt_hit_pf, .tgt_hit_io, .tgt_io_abort, .xlate_base, .tgt_start,
      .tgt_cmd, .tgt_addr, .tgt_be, .tgt_dphase, .tgt_wdata, .tgt_end,
      .m2p_write_pending, .tgt_rsp_valid, .tgt_rsp, .tgt_rdata, .np_busy,
      .npm_address, .npm_write, .npm_read, .npm_writedata,
      .npm_byteenable, .npm_waitrequest, .npm_readdata,
      .npm_readdatavalid);
   ptnwp_slave_model u_slv (.sys_clk, .sys_rst, .wait_cyc, .npm_write,
      .npm_read, .npm_address, .npm_writedata, .npm_byteenable,
      .npm_waitrequest, .npm_readdata, .npm_readdatavalid);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic give_verdict;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic req(input logic [3:0] c, input logic [31:0] a,
      input logic [3:0] b, input logic [3:0] h, input logic [2:0] e);
      @(negedge sys_clk);
      tgt_start = 1'b1;
      tgt_cmd = c;
      tgt_addr = a;
      tgt_be = b;
      {tgt_io_abort, tgt_hit_io, tgt_hit_pf, tgt_hit_np} = h;
      @(negedge sys_clk);
      tgt_start = 1'b0;
      check_val({28'h0, tgt_rsp_valid, tgt_rsp}, {28'h0, e != 3'h0, e});
   endtask
   task automatic dph(input logic [31:0] d, input logic [3:0] b);
      @(negedge sys_clk);
      tgt_dphase = 1'b1;
      tgt_wdata = d;
      tgt_be = b;
      @(negedge sys_clk);
      tgt_dphase = 1'b0;
   endtask
   task automatic wr_done(input int n, input logic [31:0] a, d);
      for (int i = 0; i < 30 && u_slv.wr_cnt == n; i++) @(negedge sys_clk);
      check_val(u_slv.last_addr, {XB[31:20], a[19:0]});
      check_val(u_slv.last_data, d);
      check_val(32'(u_slv.last_be), 32'h5);
      repeat (3) @(negedge sys_clk);
      check_val(32'(u_slv.wr_cnt), 32'(n + 1));
      check_val({31'h0, np_busy}, 32'h0);
   endtask
   task automatic t_route;
      logic [3:0] c [5] = '{CMD_CFG_RD, CMD_CFG_WR, CMD_MEM_RD, CMD_MEM_WR,
         4'h1};
      logic [3:0] h [5] = '{4'h0, 4'h0, 4'h2, 4'h0, 4'h1};
      logic [2:0] e [5] = '{RSP_TO_CFG, RSP_TO_CFG, RSP_TO_PF, RSP_NONE,
         RSP_NONE};
      for (int k = 0; k < 5; k++) req(c[k], 32'h40, 4'hF, h[k], e[k]);
   endtask
   task automatic t_write;
      int n;
      logic [31:0] a;
      wait_cyc = 4'h3;
      for (int k = 0; k < 2; k++) begin
         n = u_slv.wr_cnt;
         a = 32'h0F01_2300 + 32'(k * 16);
         req(k ? CMD_MEM_WRI : CMD_MEM_WR, a, 4'hF, 4'h1, RSP_WR_DISC);
         req(CMD_MEM_WR, 32'h800, 4'hF, 4'h1, RSP_RETRY);
         dph(32'hCAFE_0000 + 32'(k), 4'h5);
         dph(32'hDEAD_BEEF, 4'hF);
         wr_done(n, a, 32'hCAFE_0000 + 32'(k));
      end
      n = u_slv.wr_cnt;
      req(CMD_MEM_WR, 32'h800, 4'hF, 4'h1, RSP_WR_DISC);
      dph(32'h0000_1111, 4'h5);
      wr_done(n, 32'h800, 32'h0000_1111);
   endtask
   task automatic t_io;
      int n;
      wait_cyc = 4'h0;
      n = u_slv.wr_cnt;
      req(CMD_IO_WR, 32'h404, 4'hF, 4'h4, RSP_WR_DISC);
      dph(32'h1234_5678, 4'h5);
      wr_done(n, 32'h404, 32'h1234_5678);
      req(CMD_IO_WR, 32'h408, 4'hF, 4'hC, RSP_ABORT);
      // claimed write abandoned without a data phase
      req(CMD_MEM_WR, 32'h40C, 4'hF, 4'h1, RSP_WR_DISC);
      @(negedge sys_clk);
      tgt_end = 1'b1;
      @(negedge sys_clk);
      tgt_end = 1'b0;
      repeat (2) @(negedge sys_clk);
      check_val({31'h0, np_busy}, 32'h0);
      check_val(32'(u_slv.wr_cnt), 32'(n + 1));
   endtask
   task automatic t_read(input logic [31:0] a);
      req(CMD_MEM_RD, a, 4'h3, 4'h1, RSP_RETRY);
      for (int i = 0; i < 20 && !npm_readdatavalid; i++) @(negedge sys_clk);
      req(CMD_MEM_WR, 32'h100, 4'hF, 4'h1, RSP_RETRY);
      req(CMD_MEM_RD, a, 4'h7, 4'h1, RSP_RETRY);
      // opposite-direction write holds back the completion
      m2p_write_pending = 1'b1;
      req(CMD_MEM_RD, a, 4'h3, 4'h1, RSP_RETRY);
      m2p_write_pending = 1'b0;
      req(CMD_MEM_RD, a, 4'h3, 4'h1, RSP_RD_DISC);
      check_val(tgt_rdata, {XB[31:20], a[19:0]} ^ 32'h5A5A_5A5A);
      check_val({31'h0, np_busy}, 32'h0);
   endtask
   task automatic t_late;
      req(CMD_MEM_RD, 32'h0005_0020, 4'h3, 4'h1, RSP_RETRY);
      repeat (40) @(negedge sys_clk);
      check_val({31'h0, np_busy}, 32'h0);
      req(CMD_MEM_RD, 32'h0005_0020, 4'h3, 4'h1, RSP_RETRY);
      t_read(32'h0005_0020);
   endtask
   initial begin
      {tgt_start, tgt_dphase, tgt_end, m2p_write_pending} = 4'h0;
      {tgt_io_abort, tgt_hit_io, tgt_hit_pf, tgt_hit_np} = 4'h0;
      {tgt_cmd, tgt_be, tgt_addr, tgt_wdata} = '0;
      xlate_base = XB;
      wait_cyc = 4'h0;
      err_count = 0;
      compares = 0;
      sys_rst = 1'b1;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_route;
      t_write;
      t_io;
      t_read(32'h0003_0010);
      t_late;
      give_verdict;
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      err_count++;
      give_verdict;
   end
endmodule // ptnwp_target_tb_top
